// ### design/besw_cmd_if.sv
// Command carrier between the state word and the line walker
`timescale 1ns/1ps
interface besw_cmd_if;
   logic       start;
   logic [2:0] first_bit;
   logic       byte_packed;
   logic [15:0] line_bits;
   logic       busy;
   logic       skip;
   modport ctrl (output start, first_bit, byte_packed, line_bits,
                 input busy, skip);
   modport walk (input start, first_bit, byte_packed, line_bits,
                 output busy, skip);
endinterface

// ### design/besw_line_walker.sv
// Walks one monochrome source scan line and skips to a word boundary
`timescale 1ns/1ps
module besw_line_walker (
   input  wire logic hclk,     // Clock
   input  wire logic hresetn,  // Async reset, active low
   besw_cmd_if.walk  cmd       // Line command
);
   besw_pkg::besw_state_t state;
   besw_pkg::besw_state_t next_state;
   logic [15:0] pos;
   logic [15:0] next_pos;
   logic [15:0] end_pos;
   logic [15:0] end_reg;
   logic [15:0] next_end;
   logic [15:0] word_mask;
   logic        at_end;
   logic        at_word;

   // Byte packing steps whole bytes, so the first bit is dropped
   assign end_pos   = cmd.line_bits + (cmd.byte_packed ? 16'h0000 :
                      {13'h0000, cmd.first_bit});
   assign word_mask = besw_pkg::WORD_MASK;
   // Line length is only valid with the start pulse, so the end is kept
   assign at_end    = (pos + 16'h0001) >= end_reg;
   assign at_word   = ((pos + 16'h0001) & word_mask) == 16'h0000;

   always_comb begin
      next_state = state;
      next_pos   = pos;
      next_end   = end_reg;
      case (state)
         besw_pkg::BESW_IDLE: begin
            if (cmd.start) begin
               next_pos   = cmd.byte_packed ? 16'h0000 :
                            {13'h0000, cmd.first_bit};
               next_end   = end_pos;
               next_state = besw_pkg::BESW_LINE;
            end
         end
         besw_pkg::BESW_LINE: begin
            next_pos = pos + 16'h0001;
            if (at_end)
               next_state = at_word ? besw_pkg::BESW_IDLE
                                    : besw_pkg::BESW_SKIP;
         end
         besw_pkg::BESW_SKIP: begin
            next_pos = pos + 16'h0001;
            if (at_word)
               next_state = besw_pkg::BESW_IDLE;
         end
         default: next_state = besw_pkg::BESW_IDLE;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state    <= besw_pkg::BESW_IDLE;
         pos      <= 16'h0000;
         end_reg  <= 16'h0000;
         cmd.busy <= 1'b0;
         cmd.skip <= 1'b0;
      end else begin
         state    <= next_state;
         pos      <= next_pos;
         end_reg  <= next_end;
         cmd.busy <= next_state != besw_pkg::BESW_IDLE;
         cmd.skip <= next_state == besw_pkg::BESW_SKIP;
      end
   end
endmodule

// ### design/besw_pkg.sv
// Constants and types for the block-transfer engine state word
// Contract
// - Pattern-type bit from decoded setup opcode
// - Hold last transfer opcode in 28:22
// - Engine decodes stored opcode for operation
// - Channel write mask applies only at 32bpp
// - Mono source start bit within a byte
// - Mono lines word aligned, discard tail bits
// - Packing bit: 0 bit packed, 1 byte
package besw_pkg;
   localparam logic [31:0] BESW_STATE_ADDR = 32'h0000_0000;
   localparam logic [31:0] BESW_CTRL_ADDR  = 32'h0000_0004;
   localparam logic [31:0] BESW_STAT_ADDR  = 32'h0000_0008;
   localparam int PAT_BIT   = 29;
   localparam int OP_HI     = 28;
   localparam int OP_LO     = 22;
   localparam int MASK_HI   = 21;
   localparam int MASK_LO   = 20;
   localparam int START_HI  = 19;
   localparam int START_LO  = 17;
   localparam int PACK_BIT  = 16;
   localparam int MASK_ALPHA = 1;
   localparam int MASK_RGB   = 0;
   localparam logic [6:0] OP_RESET    = 7'h00;
   localparam logic [1:0] MASK_RESET  = 2'h0;
   localparam logic [2:0] START_RESET = 3'h0;
   // Opcode classes: bit 0 flags mono source, bit 1 mono pattern
   localparam int OP_SRC_MONO_BIT = 0;
   localparam int OP_PAT_MONO_BIT = 1;
   // Bit position mask within one 32-bit monochrome source word
   localparam logic [15:0] WORD_MASK = 16'h001F;
   typedef enum logic [1:0] {BESW_IDLE, BESW_LINE, BESW_SKIP} besw_state_t;
endpackage

// ### design/besw_top.sv
// Block-transfer engine state word with AHB-Lite read-back
//
// Chosen here: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module besw_top (
   input  wire logic        hclk,          // Clock, 50 MHz
   input  wire logic        hresetn,       // Async reset, active low
   input  wire logic        hsel,          // Slave select
   input  wire logic [31:0] haddr,         // Address
   input  wire logic [1:0]  htrans,        // Transfer type
   input  wire logic        hwrite,        // Write
   input  wire logic [2:0]  hsize,         // Size
   input  wire logic        hready,        // Bus ready
   input  wire logic [31:0] hwdata,        // Write data
   output logic [31:0]      hrdata,        // Read data
   output logic             hreadyout,     // Slave ready
   output logic             hresp,         // Response, always OKAY
   input  wire logic        setup_valid,   // Setup command accepted
   input  wire logic        setup_mono,    // Setup opcode mono pattern
   input  wire logic        blt_valid,     // Transfer command accepted
   input  wire logic [6:0]  blt_opcode,    // Transfer opcode
   input  wire logic [1:0]  blt_mask,      // Channel write mask
   input  wire logic [2:0]  blt_start,     // Mono start bit
   input  wire logic        blt_bytepack,  // Mono byte packed
   input  wire logic        line_go,       // Start a mono scan line
   input  wire logic [15:0] line_bits,     // Pixels in that line
   output logic             src_mono,      // Stored op: mono source
   output logic             pat_mono,      // Stored op: mono pattern
   output logic             alpha_we,      // Alpha bytes writable
   output logic             rgb_we,        // RGB bytes writable
   output logic             line_busy,     // Line walk in progress
   output logic             line_skip      // Discarding to word end
);
   logic        pattern_mono;
   logic [6:0]  opcode;
   logic [1:0]  channel_write_mask;
   logic [2:0]  mono_start;
   logic        byte_packed;
   logic        bpp32;
   logic        dphase;
   logic [31:0] dph_addr;
   logic        dph_write;
   logic [31:0] state_word;
   logic [31:0] ctrl_word;
   logic [31:0] stat_word;
   logic [31:0] next_rdata;
   logic        addr_ok;
   logic        wr_ctrl;

   besw_cmd_if cmd ();

   besw_line_walker u_walk (
      .hclk    (hclk),
      .hresetn (hresetn),
      .cmd     (cmd)
   );

   assign cmd.start       = line_go & ~cmd.busy;
   assign cmd.first_bit   = mono_start;
   assign cmd.byte_packed = byte_packed;
   assign cmd.line_bits   = line_bits;

   assign addr_ok = hsel & hready & htrans[1];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dphase    <= 1'b0;
         dph_addr  <= 32'h0000_0000;
         dph_write <= 1'b0;
      end else if (hready) begin
         dphase    <= addr_ok;
         dph_addr  <= haddr;
         dph_write <= hwrite;
      end
   end

   // Only the control word is writable; the state word ignores writes
   assign wr_ctrl = dphase & dph_write &
                    (dph_addr == besw_pkg::BESW_CTRL_ADDR);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         bpp32 <= 1'b0;
      else if (wr_ctrl)
         bpp32 <= hwdata[0];
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         pattern_mono <= 1'b0;
      else if (setup_valid)
         pattern_mono <= setup_mono;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         opcode             <= besw_pkg::OP_RESET;
         channel_write_mask <= besw_pkg::MASK_RESET;
         mono_start         <= besw_pkg::START_RESET;
         byte_packed        <= 1'b0;
      end else if (blt_valid) begin
         opcode             <= blt_opcode;
         channel_write_mask <= blt_mask;
         mono_start         <= blt_start;
         byte_packed        <= blt_bytepack;
      end
   end

   always_comb begin
      state_word = 32'h0000_0000;
      state_word[besw_pkg::PAT_BIT] = pattern_mono;
      state_word[besw_pkg::OP_HI:besw_pkg::OP_LO] = opcode;
      state_word[besw_pkg::MASK_HI:besw_pkg::MASK_LO] = channel_write_mask;
      state_word[besw_pkg::START_HI:besw_pkg::START_LO] = mono_start;
      state_word[besw_pkg::PACK_BIT] = byte_packed;
   end

   assign ctrl_word = {31'h0000_0000, bpp32};
   assign stat_word = {30'h0000_0000, cmd.skip, cmd.busy};

   assign next_rdata = (haddr == besw_pkg::BESW_STATE_ADDR) ? state_word :
                       (haddr == besw_pkg::BESW_CTRL_ADDR)  ? ctrl_word  :
                       (haddr == besw_pkg::BESW_STAT_ADDR)  ? stat_word  :
                       32'h0000_0000;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         hrdata <= 32'h0000_0000;
      else if (addr_ok & ~hwrite)
         hrdata <= next_rdata;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         src_mono  <= 1'b0;
         pat_mono  <= 1'b0;
         alpha_we  <= 1'b0;
         rgb_we    <= 1'b0;
         line_busy <= 1'b0;
         line_skip <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         src_mono  <= opcode[besw_pkg::OP_SRC_MONO_BIT];
         pat_mono  <= opcode[besw_pkg::OP_PAT_MONO_BIT];
         alpha_we  <= ~bpp32 | channel_write_mask[besw_pkg::MASK_ALPHA];
         rgb_we    <= ~bpp32 | channel_write_mask[besw_pkg::MASK_RGB];
         line_busy <= cmd.busy;
         line_skip <= cmd.skip;
      end
   end
endmodule

// ### verification/besw_cmd_model.sv
// Command decoder model issuing accepted commands
`timescale 1ns/1ps
module besw_cmd_model (
   input  wire logic   hclk,         // Clock
   output logic        setup_valid,  // Setup accepted
   output logic        setup_mono,   // Mono pattern
   output logic        blt_valid,    // Transfer accepted
   output logic [6:0]  blt_opcode,   // Opcode
   output logic [1:0]  blt_mask,     // Write mask
   output logic [2:0]  blt_start,    // Start bit
   output logic        blt_bytepack, // Byte packed
   output logic        line_go,      // Line start
   output logic [15:0] line_bits     // Line length
);
   initial begin
      {setup_valid, setup_mono, blt_valid, line_go} = 4'h0;
      {blt_opcode, blt_mask, blt_start, blt_bytepack} = 13'h0000;
      line_bits = 16'h0000;
   end
   task automatic setup(input logic mo);
      @(posedge hclk);
      setup_valid <= 1'b1;
      setup_mono <= mo;
      @(posedge hclk);
      setup_valid <= 1'b0;
      setup_mono <= ~mo;
   endtask
   task automatic blt(input logic [6:0] op, input logic [1:0] mk,
                      input logic [2:0] st, input logic pk);
      @(posedge hclk);
      blt_valid <= 1'b1;
      {blt_opcode, blt_mask, blt_start, blt_bytepack} <= {op, mk, st, pk};
      @(posedge hclk);
      blt_valid <= 1'b0;
      {blt_opcode, blt_mask, blt_start, blt_bytepack} <= ~{op, mk, st, pk};
   endtask
   // length held only for the pulse
   task automatic line(input logic [15:0] b);
      @(posedge hclk);
      line_go <= 1'b1;
      line_bits <= b;
      @(posedge hclk);
      line_go <= 1'b0;
      line_bits <= ~b;
   endtask
endmodule

// ### verification/besw_top_assertions.sv
// Port checks for the state word block
`timescale 1ns/1ps
module besw_top_assertions (
   input wire logic        hclk,       // Clock
   input wire logic        hresetn,    // Reset, active low
   input wire logic        hsel,       // Select
   input wire logic [31:0] haddr,      // Address
   input wire logic [1:0]  htrans,     // Transfer type
   input wire logic        hwrite,     // Write
   input wire logic        hreadyout,  // Slave ready
   input wire logic        hresp,      // Response
   input wire logic [31:0] hrdata,     // Read data
   input wire logic        blt_valid,  // Transfer accepted
   input wire logic [6:0]  blt_opcode, // Opcode
   input wire logic        line_go,    // Line start
   input wire logic [15:0] line_bits,  // Line length
   input wire logic        src_mono,   // Mono source
   input wire logic        pat_mono,   // Mono pattern
   input wire logic        line_busy,  // Walking
   input wire logic        line_skip   // Skipping
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   a_ready_high: assert property (hreadyout)
      else $error("ready low");
   a_resp_okay: assert property (!hresp)
      else $error("error response");
   a_src_class: assert property (blt_valid |->
      ##2 src_mono == $past(blt_opcode[0], 2)) else $error("src class");
   a_pat_class: assert property (blt_valid |->
      ##2 pat_mono == $past(blt_opcode[1], 2)) else $error("pat class");
   a_class_hold: assert property ($changed({src_mono, pat_mono}) |->
      $past(blt_valid, 2)) else $error("class moved");
   a_unmapped_rd: assert property (hsel && htrans[1] && !hwrite
      && hreadyout && haddr == 32'h0000_0010 |=> hrdata == 32'h0000_0000)
      else $error("unmapped read");
   a_line_start: assert property (line_go && !line_busy
      && line_bits != 16'h0000 |-> ##[1:3] line_busy) else $error("no walk");
   a_skip_busy: assert property (line_skip |-> line_busy)
      else $error("skip idle");
   cover property (blt_valid);
   cover property ($rose(line_skip));
   cover property ($fell(line_busy));
endmodule
bind besw_top besw_top_assertions chk (.*);

// ### verification/tb_besw_top.sv
// Self-checking bench for the state word block
`timescale 1ns/1ps
module tb_besw_top;
   logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, q;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic        setup_valid, setup_mono, blt_valid, blt_bytepack, line_go;
   logic [6:0]  blt_opcode, op;
   logic [1:0]  blt_mask;
   logic [2:0]  blt_start;
   logic [15:0] line_bits;
   logic        src_mono, pat_mono, alpha_we, rgb_we, line_busy, line_skip;
   int          err_total, check_count;
   besw_top DUT (.hready(hreadyout), .*);
   besw_cmd_model m (.*);
   initial begin
      hclk = 1'b0;
      forever #10 hclk = ~hclk;
   end
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] s, e);
      check_count++;
      if (s !== e) begin
         err_total++;
         $display("mismatch at %0t seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic bus(input logic wr, input logic [31:0] a, d);
      int n;
      n = 0;
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= wr;
      haddr <= a;
      do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 50);
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 50);
      q = hrdata;
      if (n >= 50) begin
         err_total++;
         print_verdict();
      end
   endtask
   task automatic rd(input logic [31:0] a, e);
      bus(1'b0, a, 32'h0000_0000);
      chk(q, e);
   endtask
   task automatic walk(input logic [15:0] b, input int e);
      int n, k;
      n = 0;
      k = 0;
      m.line(b);
      while (line_busy !== 1'b1 && n < 9) begin
         @(posedge hclk);
         n++;
      end
      if (line_busy !== 1'b1) begin
         err_total++;
         print_verdict();
      end
      while (line_busy === 1'b1 && n < 300) begin
         @(posedge hclk);
         n++;
         k += int'(line_skip === 1'b1);
      end
      if (line_busy === 1'b1) begin
         err_total++;
         print_verdict();
      end
      chk(32'(k), 32'(e));
      rd(besw_pkg::BESW_STAT_ADDR, 32'h0000_0000);
   endtask
   initial begin
      {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
      hsize = 3'h2;
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rd(besw_pkg::BESW_STATE_ADDR, 32'h0000_0000);
      rd(32'h0000_0010, 32'h0000_0000);
      bus(1'b1, besw_pkg::BESW_STATE_ADDR, 32'hFFFF_FFFF);
      rd(besw_pkg::BESW_STATE_ADDR, 32'h0000_0000);
      $display("test reset done");
      for (int i = 0; i < 4; i++) begin
         op = {5'(i * 7 + 3), 2'(i)};
         m.setup(i[1]);
         m.blt(op, 2'(i), 3'(i * 3 + 4), i[0]);
         rd(besw_pkg::BESW_STATE_ADDR, {2'b00, i[1], op, 2'(i),
            3'(i * 3 + 4), i[0], 16'h0000});
         chk({30'h0, pat_mono, src_mono}, {30'h0, op[1:0]});
      end
      $display("test fields done");
      bus(1'b1, besw_pkg::BESW_CTRL_ADDR, 32'h0000_0001);
      rd(besw_pkg::BESW_CTRL_ADDR, 32'h0000_0001);
      for (int j = 0; j < 4; j++) begin
         m.blt(7'h00, 2'(j), 3'h0, 1'b0);
         repeat (3) @(posedge hclk);
         chk({30'h0, alpha_we, rgb_we}, 32'(j));
      end
      bus(1'b1, besw_pkg::BESW_CTRL_ADDR, 32'h0000_0000);
      repeat (2) @(posedge hclk);
      chk({30'h0, alpha_we, rgb_we}, 32'h0000_0003);
      $display("test mask done");
      m.blt(7'h01, 2'b00, 3'h3, 1'b0);
      walk(16'h0005, 24);
      m.blt(7'h01, 2'b00, 3'h3, 1'b1);
      walk(16'h0028, 24);
      $display("test line done");
      print_verdict();
   end
endmodule
